/* hdl/slsc_top.sv */
// Serial load switch controller: control word, status word, switch
// enables and fault timing for three high-side and three low-side outputs.
// Assumes analog comparators deliver short, open-load, supply and
// temperature levels as asynchronous inputs.
//
// Behaviour
// - Chip select falling edge starts a transfer
// - Data in sampled on falling clock edges
// - New control word applied on chip select rise
// - Data out released while chip select high
// - Data out changes on rising clock edges
// - Status shifted LSB first, bit 0 prewarning
// - Clear bit resets supply, short, overtemperature flags
// - Control bits 1..6 switch the six outputs
// - Control bit 13 low enables open-load check
// - Control bit 14 selects long or short delays
// - Control bit 15 low means standby
// - Status 1..6 show output state or open load
// - Status 13 set when short turned output off
// - Status 14 shows software or hardware standby
// - Status 15 is the supply fault flag
// - Overtemperature shutdown reports all status bits high
// - Reset control word: 15..13 high, rest low
// - Supply fault after selected delay disables outputs
// - Supply recovery re-enables outputs, flag stays
// - Open-load check drives currents, flags low voltage
// - Switched-on output or software standby stops open-load check
// - Applied transfers move sixteen bits each way; shorter ones change nothing
// - Inhibit pin low forces standby
`timescale 1ns/1ps
module slsc_top #(
  parameter int unsigned SC_LONG_CYC = slsc_pkg::SC_LONG_CYC,
  parameter int unsigned SC_SHORT_CYC = slsc_pkg::SC_SHORT_CYC,
  parameter int unsigned SV_LONG_CYC = slsc_pkg::SV_LONG_CYC,
  parameter int unsigned SV_SHORT_CYC = slsc_pkg::SV_SHORT_CYC
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_oe_n,
  // Hardware inhibit pin, low means standby
  input wire logic run_enable_pin,
  // Comparator levels from the analog side
  input wire logic thermal_prewarn_in,
  input wire logic overtemp_in,
  input wire logic load_supply_bad,
  input wire logic [slsc_pkg::N_SW-1:0] short_in,
  input wire logic [slsc_pkg::N_SW-1:0] open_load_in,
  // Output stage controls, order low 1, high 1, low 2, high 2, low 3, high 3
  output logic [slsc_pkg::N_SW-1:0] switch_on,
  output logic [slsc_pkg::N_SW-1:0] open_load_src_en
);

  // Short local names for the package sizes
  localparam int WW = slsc_pkg::WORD_W;
  localparam int NS = slsc_pkg::N_SW;
  localparam int CW = slsc_pkg::CNT_W;
  localparam int GW = slsc_pkg::GRAY_W;

  // Delay limits sized to the timer width
  localparam logic [CW-1:0] SC_LONG_LIM = CW'(SC_LONG_CYC);
  localparam logic [CW-1:0] SC_SHORT_LIM = CW'(SC_SHORT_CYC);
  localparam logic [CW-1:0] SV_LONG_LIM = CW'(SV_LONG_CYC);
  localparam logic [CW-1:0] SV_SHORT_LIM = CW'(SV_SHORT_CYC);

  // All core state in one record
  typedef struct packed {
    // Two-stage synchronisers, stage 1 feeds only stage 2
    logic cs_s1;
    logic cs_s2;
    logic cs_s3; // Previous synced chip select, for edges
    logic run_s1;
    logic run_s2;
    logic pw_s1;
    logic pw_s2;
    logic ot_s1;
    logic ot_s2;
    logic sb_s1;
    logic sb_s2;
    logic [NS-1:0] sh_s1;
    logic [NS-1:0] sh_s2;
    logic [NS-1:0] ol_s1;
    logic [NS-1:0] ol_s2;
    logic [GW-1:0] rxg_s1;
    logic [GW-1:0] rxg_s2;
    logic [GW-1:0] txg_s1;
    logic [GW-1:0] txg_s2;
    // Frame bookkeeping
    logic [GW-1:0] rx_start;
    logic [GW-1:0] tx_start;
    logic [WW-1:0] snap;
    // Registers and flags
    logic [WW-1:0] ctrl;
    logic [NS-1:0] short_off;
    logic short_det;
    logic supply_fault;
    logic otsd;
    // Fault timers
    logic [CW-1:0] sc_cnt;
    logic sc_done;
    logic [CW-1:0] sv_cnt;
    logic sv_done;
    // Pin drivers
    logic sdo;
    logic sdo_oe_n;
    logic [NS-1:0] drive;
    logic [NS-1:0] ol_src;
  } slsc_core_t;

  // Registered state and the value it takes at the next edge
  slsc_core_t q, d;

  // Link-domain results
  // The word is read only once the synchronised counts show that a frame has ended
  logic [WW-1:0] rx_word;
  logic [GW-1:0] rx_cnt_gray;
  logic [GW-1:0] tx_cnt_gray;

  // One step of a fault timer; returns done flag over count.
  // Done holds while run stays high and clears as soon as run drops.
  // Reaching or passing the limit ends the count, so a shorter delay
  // chosen mid-count cannot let the count run on until it wraps.
  function automatic logic [CW:0] tmr_step(input logic run,
                                           input logic [CW-1:0] cnt,
                                           input logic done,
                                           input logic [CW-1:0] lim);
    if (!run) begin
      return '0;
    end else if (done) begin
      return {1'b1, cnt};
    end else if (cnt >= lim - slsc_pkg::CNT_ONE) begin
      return {1'b1, cnt};
    end else begin
      return {1'b0, cnt + slsc_pkg::CNT_ONE};
    end
  endfunction

  // Serial clock front end
  slsc_link u_link (
    .sclk(sclk),
    .rst(rst),
    .serial_data_in(serial_data_in),
    .rx_word(rx_word),
    .rx_cnt_gray(rx_cnt_gray),
    .tx_cnt_gray(tx_cnt_gray)
  );

  // Combinational next state
  always_comb begin
    logic cs_fall;
    logic cs_rise;
    logic standby;
    logic sv_off;
    logic kill_all;
    logic ol_active;
    logic [NS-1:0] shorted;
    logic [WW-1:0] status;
    logic [GW-1:0] rx_bits;
    logic [GW-1:0] tx_idx;
    logic [CW-1:0] sc_lim;
    logic [CW-1:0] sv_lim;
    logic [CW:0] sc_nx;
    logic [CW:0] sv_nx;
    logic do_apply;
    logic do_clear;
    // Everything holds unless a branch below says otherwise
    d = q;
    // Locals start at zero so no latch is implied
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    standby = 1'b0;
    sv_off = 1'b0;
    kill_all = 1'b0;
    ol_active = 1'b0;
    shorted = '0;
    status = '0;
    rx_bits = '0;
    tx_idx = '0;
    sc_lim = '0;
    sv_lim = '0;
    sc_nx = '0;
    sv_nx = '0;
    do_apply = 1'b0;
    do_clear = 1'b0;

    // Synchroniser chains
    d.cs_s1 = cs_n;
    d.cs_s2 = q.cs_s1;
    d.cs_s3 = q.cs_s2;
    d.run_s1 = run_enable_pin;
    d.run_s2 = q.run_s1;
    d.pw_s1 = thermal_prewarn_in;
    d.pw_s2 = q.pw_s1;
    d.ot_s1 = overtemp_in;
    d.ot_s2 = q.ot_s1;
    d.sb_s1 = load_supply_bad;
    d.sb_s2 = q.sb_s1;
    d.sh_s1 = short_in;
    d.sh_s2 = q.sh_s1;
    d.ol_s1 = open_load_in;
    d.ol_s2 = q.ol_s1;
    d.rxg_s1 = rx_cnt_gray;
    d.rxg_s2 = q.rxg_s1;
    d.txg_s1 = tx_cnt_gray;
    d.txg_s2 = q.txg_s1;

    // Chip select edges seen in the core domain
    // The third stage holds the previous level; stage one feeds only stage two
    cs_fall = q.cs_s3 & ~q.cs_s2;
    cs_rise = ~q.cs_s3 & q.cs_s2;

    // Standby from software bit or inhibit pin
    standby = ~q.ctrl[slsc_pkg::CTL_RUN] | ~q.run_s2;

    // Supply timer, delay picked by the select bit
    if (q.ctrl[slsc_pkg::CTL_DELAY_SEL]) begin
      sc_lim = SC_LONG_LIM;
      sv_lim = SV_LONG_LIM;
    end else begin
      sc_lim = SC_SHORT_LIM;
      sv_lim = SV_SHORT_LIM;
    end
    sv_nx = tmr_step(q.sb_s2, q.sv_cnt, q.sv_done, sv_lim);
    d.sv_done = sv_nx[CW];
    d.sv_cnt = sv_nx[CW-1:0];
    // Outputs come back as soon as the supply is good again
    sv_off = q.sv_done & q.sb_s2;

    // Any one of these forces every output stage off
    kill_all = standby | sv_off | q.otsd;

    // Short timer runs while any switched-on output is shorted
    shorted = q.sh_s2 & q.drive;
    sc_nx = tmr_step(|shorted, q.sc_cnt, q.sc_done, sc_lim);
    d.sc_done = sc_nx[CW];
    d.sc_cnt = sc_nx[CW-1:0];

    // Status word, built from live state
    status[slsc_pkg::ST_PREWARN] = q.pw_s2;
    for (int i = 0; i < NS; i++) begin
      // Open-load result while checking, else on/off state
      status[slsc_pkg::ST_SW_LSB + i] = q.ol_src[i] ? q.ol_s2[i] : q.drive[i];
    end
    status[slsc_pkg::ST_SHORT] = q.short_det;
    status[slsc_pkg::ST_STANDBY] = standby;
    status[slsc_pkg::ST_SUPPLY] = q.supply_fault;
    // Shutdown overrides every bit, prewarning included
    if (q.otsd) begin
      status = slsc_pkg::STATUS_OTSD;
    end

    // Frame start: snapshot status, drive the first bit
    if (cs_fall) begin
      d.snap = status;
      d.sdo = status[0];
      d.sdo_oe_n = 1'b0;
      // Start marks let the free-running link counts be read per frame
      d.tx_start = slsc_pkg::gray2bin(q.txg_s2);
      d.rx_start = slsc_pkg::gray2bin(q.rxg_s2);
    end else if (cs_rise) begin
      // Frame end: release the line, maybe apply the word
      d.sdo_oe_n = 1'b1;
      rx_bits = slsc_pkg::gray2bin(q.rxg_s2) - q.rx_start;
      // Short frames, such as a prewarning peek, change nothing
      do_apply = (rx_bits == slsc_pkg::FRAME_BITS);
    end else if (!q.cs_s2) begin
      // Next bit after each rising serial clock edge
      tx_idx = slsc_pkg::gray2bin(q.txg_s2) - q.tx_start;
      // From sixteen to thirty-one rises the last bit stays on the line
      if (tx_idx < slsc_pkg::FRAME_BITS) begin
        d.sdo = q.snap[tx_idx[3:0]];
      end
    end

    // Apply the received control word
    // The shifter is quiet here: the link clock idles once the rise is seen
    if (do_apply) begin
      d.ctrl = rx_word;
      do_clear = rx_word[slsc_pkg::CTL_STATUS_CLEAR];
    end

    // Sticky flag clears first, so a set in this cycle wins
    if (do_clear) begin
      d.supply_fault = 1'b0;
      d.short_det = 1'b0;
      // Latched short-offs are released along with the flag
      d.short_off = '0;
      d.otsd = 1'b0;
    end
    if (q.sv_done && q.sb_s2) begin
      d.supply_fault = 1'b1;
    end
    // Shorted outputs go off after the delay, or at once when hot
    if (q.sc_done || (q.pw_s2 && |shorted)) begin
      d.short_off = d.short_off | shorted;
      d.short_det = 1'b1;
    end
    // Shutdown latches while hot; clearing needs a cool die
    if (q.ot_s2) begin
      d.otsd = 1'b1;
    end

    // Output stages follow the control bits unless blocked
    // A latched short-off or any kill cause beats the control bit
    for (int i = 0; i < NS; i++) begin
      d.drive[i] = q.ctrl[slsc_pkg::CTL_SW_LSB + i] & ~kill_all & ~q.short_off[i];
    end

    // Open-load currents only on switched-off outputs, not in software standby
    // The inhibit pin leaves the currents alone; only the software bit stops them
    ol_active = ~q.ctrl[slsc_pkg::CTL_OL_EN_N] & q.ctrl[slsc_pkg::CTL_RUN];
    for (int i = 0; i < NS; i++) begin
      d.ol_src[i] = ol_active & ~q.ctrl[slsc_pkg::CTL_SW_LSB + i];
    end
  end

  // State register; only constants under reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      // Chip select resets high, so no false frame start follows reset
      q.cs_s1 <= 1'b1;
      q.cs_s2 <= 1'b1;
      q.cs_s3 <= 1'b1;
      q.ctrl <= slsc_pkg::CTRL_RESET;
      q.sdo_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Pins straight from flip-flops
  // Data out is always driven; the enable tells the pad when it counts
  assign serial_data_out = q.sdo;
  assign serial_data_out_oe_n = q.sdo_oe_n;
  assign switch_on = q.drive;
  assign open_load_src_en = q.ol_src;

endmodule

/* hdl/slsc_pkg.sv */
// Shared constants for the serial load switch controller.
// Assumes a 250 MHz core clock; all timing counts derive from it.
package slsc_pkg;

  // Word and vector sizes
  localparam int WORD_W = 16;
  localparam int N_SW = 6;
  localparam int CNT_W = 25;
  localparam int GRAY_W = 5;

  // Control word bit positions (outputs 1..6 follow the LSB position)
  localparam int CTL_STATUS_CLEAR = 0;
  localparam int CTL_SW_LSB = 1;
  localparam int CTL_OL_EN_N = 13;
  localparam int CTL_DELAY_SEL = 14;
  localparam int CTL_RUN = 15;

  // Status word bit positions
  localparam int ST_PREWARN = 0;
  localparam int ST_SW_LSB = 1;
  localparam int ST_SHORT = 13;
  localparam int ST_STANDBY = 14;
  localparam int ST_SUPPLY = 15;

  // Control word after reset: run, long delays, open-load check off
  localparam logic [WORD_W-1:0] CTRL_RESET = 16'he000;
  // All-high status during overtemperature shutdown
  localparam logic [WORD_W-1:0] STATUS_OTSD = 16'hffff;
  // Bits in a complete frame
  localparam logic [GRAY_W-1:0] FRAME_BITS = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ONE = 25'h0000001;

  // Fault delays in microseconds, and the core clock rate
  localparam int CORE_CLK_MHZ = 250;
  localparam int SC_LONG_US = 100000;
  localparam int SC_SHORT_US = 12500;
  localparam int SV_LONG_US = 14000;
  localparam int SV_SHORT_US = 3500;

  // Same delays in core clock cycles
  localparam int SC_LONG_CYC = SC_LONG_US * CORE_CLK_MHZ;
  localparam int SC_SHORT_CYC = SC_SHORT_US * CORE_CLK_MHZ;
  localparam int SV_LONG_CYC = SV_LONG_US * CORE_CLK_MHZ;
  localparam int SV_SHORT_CYC = SV_SHORT_US * CORE_CLK_MHZ;

  // Binary to gray, for counters that cross clock domains
  function automatic logic [GRAY_W-1:0] bin2gray(input logic [GRAY_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  // Gray back to binary on the receiving side
  function automatic logic [GRAY_W-1:0] gray2bin(input logic [GRAY_W-1:0] g);
    logic [GRAY_W-1:0] b;
    b[GRAY_W-1] = g[GRAY_W-1];
    for (int i = GRAY_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

/* hdl/slsc_link.sv */
// Serial clock front end: shifts data in and counts clock edges.
// Assumes the serial clock only runs while chip select is low.
`timescale 1ns/1ps
module slsc_link (
  // Link clock and core reset
  input wire logic sclk,
  input wire logic rst,
  // Serial data in, valid at the falling clock edge
  input wire logic serial_data_in,
  // Results for the core domain
  output logic [slsc_pkg::WORD_W-1:0] rx_word,
  output logic [slsc_pkg::GRAY_W-1:0] rx_cnt_gray,
  output logic [slsc_pkg::GRAY_W-1:0] tx_cnt_gray
);

  // Falling-edge state: shifter and free-running edge count
  typedef struct packed {
    logic [slsc_pkg::WORD_W-1:0] sh;
    logic [slsc_pkg::GRAY_W-1:0] bin;
    logic [slsc_pkg::GRAY_W-1:0] gray;
  } slsc_rx_t;

  // Rising-edge state: free-running edge count
  typedef struct packed {
    logic [slsc_pkg::GRAY_W-1:0] bin;
    logic [slsc_pkg::GRAY_W-1:0] gray;
  } slsc_tx_t;

  slsc_rx_t rx_q, rx_d;
  slsc_tx_t tx_q, tx_d;

  // Counts never reset per frame; the core subtracts a start mark,
  // so nothing here depends on chip select or on clock after a frame
  always_comb begin
    rx_d = rx_q;
    rx_d.sh = {serial_data_in, rx_q.sh[slsc_pkg::WORD_W-1:1]};
    rx_d.bin = rx_q.bin + 5'h01;
    rx_d.gray = slsc_pkg::bin2gray(rx_d.bin);
    tx_d.bin = tx_q.bin + 5'h01;
    tx_d.gray = slsc_pkg::bin2gray(tx_d.bin);
  end

  // Sample on the falling serial clock edge
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      rx_q <= '0;
    end else begin
      rx_q <= rx_d;
    end
  end

  // Count rising serial clock edges
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      tx_q <= '0;
    end else begin
      tx_q <= tx_d;
    end
  end

  // Gray counts change one bit per edge, safe to synchronise
  assign rx_word = rx_q.sh;
  assign rx_cnt_gray = rx_q.gray;
  assign tx_cnt_gray = tx_q.gray;

endmodule

/* sim/slsc_checker.sv */
// Pin-level assertions for the load switch controller, core clock domain.
// Assumes a bind from the testbench that hands on the fault delays.
`timescale 1ns/1ps
module slsc_checker #(
  parameter int unsigned SC_LONG_CYC = 40,
  parameter int unsigned SV_LONG_CYC = 30
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe_n,
  // Pins and comparator levels
  input wire logic run_enable_pin,
  input wire logic overtemp_in,
  input wire logic load_supply_bad,
  input wire logic [slsc_pkg::N_SW-1:0] short_in,
  // Output stage
  input wire logic [slsc_pkg::N_SW-1:0] switch_on,
  input wire logic [slsc_pkg::N_SW-1:0] open_load_src_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  logic sclk_q; // Sampled link clock
  logic cs_q; // Sampled chip select
  logic [3:0] edge_age_q; // Cycles since shift edge, saturating
  logic [3:0] ev_age_q; // Cycles since a cause of switch change
  int unsigned bad_age_q; // Cycles of continuous supply fault
  int unsigned sh_age_q; // Cycles an on output sits shorted

  // Age counters; saturation keeps idle stretches harmless
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      edge_age_q <= 4'h0;
      ev_age_q <= 4'h0;
      bad_age_q <= 0;
      sh_age_q <= 0;
    end else begin
      sclk_q <= sclk;
      cs_q <= cs_n;
      edge_age_q <= ((sclk && !sclk_q) || (!cs_n && cs_q)) ? 4'h0 :
                    (edge_age_q == 4'hf) ? edge_age_q : edge_age_q + 4'h1;
      ev_age_q <= ((cs_n && !cs_q) || $changed(run_enable_pin) || $changed(overtemp_in)
                   || $changed(load_supply_bad) || $changed(short_in)) ? 4'h0 :
                  (ev_age_q == 4'hf) ? ev_age_q : ev_age_q + 4'h1;
      bad_age_q <= load_supply_bad ? bad_age_q + 1 : 0;
      sh_age_q <= ((short_in & switch_on) != '0) ? sh_age_q + 1 : 0;
    end
  end

  AST_OE_ON: assert property ($fell(cs_n) |-> ##[1:5] !serial_data_out_oe_n)
    else $error("data out not enabled after select");
  AST_OE_IDLE: assert property (cs_n [*6] |-> serial_data_out_oe_n)
    else $error("data out driven while deselected");
  AST_SDO_HOLD: assert property (($changed(serial_data_out) && !serial_data_out_oe_n
    && $past(!serial_data_out_oe_n)) |-> edge_age_q <= 4'h6)
    else $error("data out changed away from a rising clock");
  AST_SW_CAUSE: assert property (($changed(switch_on) && !load_supply_bad && !overtemp_in
    && short_in == '0 && run_enable_pin) |-> ev_age_q <= 4'h8)
    else $error("switches changed with no applied word");
  AST_HW_STANDBY: assert property (!run_enable_pin [*4] |-> switch_on == '0)
    else $error("outputs on while inhibit pin low");
  AST_OTSD_OFF: assert property (overtemp_in [*5] |-> switch_on == '0)
    else $error("outputs on in overtemperature");
  AST_OL_EXCL: assert property ((open_load_src_en & switch_on) == '0)
    else $error("open-load source on a switched-on output");
  AST_SUPPLY_OFF: assert property (bad_age_q > SV_LONG_CYC + 5 |-> switch_on == '0)
    else $error("outputs on after supply fault delay");
  AST_SHORT_OFF: assert property (sh_age_q <= SC_LONG_CYC + 6)
    else $error("shorted output not switched off in time");

  COV_FRAME: cover property ($fell(cs_n) ##[1:5] !serial_data_out_oe_n);
  COV_SUPPLY: cover property (load_supply_bad ##1 switch_on == '0);
  COV_SHORT: cover property ((short_in & switch_on) != '0 ##1 (short_in & switch_on) == '0);
endmodule

/* sim/slsc_ctrl_model.sv */
// Controller model: drives frames on the serial link, LSB first.
// Assumes the caller waits for each frame; clock idles low between frames.
`timescale 1ns/1ps
module slsc_ctrl_model (
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe_n
);
  logic lclk; // 80 ns link timebase, phase unrelated to the core
  logic sdo_line; // What the controller sees on the shared data line

  // No pull on the line: a released pin reads inverted, so a late enable shows up
  assign sdo_line = serial_data_out_oe_n ? ~serial_data_out : serial_data_out;

  // Lines start idle; data in sits at its pull-down level
  initial begin
    lclk = 1'b0;
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_data_in = 1'b0;
    #7.3;
    forever #40 lclk = ~lclk;
  end

  // One frame of n clocks; status bit i is read before rise i
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge lclk) cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge lclk);
      if (i < 16) rx[i] = sdo_line;
      sclk <= 1'b1;
      serial_data_in <= tx[i % 16];
      @(negedge lclk) sclk <= 1'b0;
    end
    @(posedge lclk) cs_n <= 1'b1;
    serial_data_in <= 1'b0;
    @(posedge lclk);
  endtask
endmodule

/* sim/slsc_top_tb.sv */
// Self-checking bench for the load switch controller.
// Assumes small fault delays; the controller model runs the link.
`timescale 1ns/1ps
module slsc_top_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic run_enable_pin = 1'b1;
  logic thermal_prewarn_in = 1'b0;
  logic overtemp_in = 1'b0;
  logic load_supply_bad = 1'b0;
  logic [5:0] short_in = 6'h00;
  logic [5:0] open_load_in = 6'h00;
  logic sclk, cs_n, serial_data_in, serial_data_out, serial_data_out_oe_n;
  logic [5:0] switch_on, open_load_src_en;
  logic [15:0] st;
  int err_total = 0;
  int checked = 0;

  always #2 core_clk = ~core_clk;

  slsc_top #(.SC_LONG_CYC(40), .SC_SHORT_CYC(20), .SV_LONG_CYC(30), .SV_SHORT_CYC(10)) dut_u (
    .core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_out_oe_n(serial_data_out_oe_n), .run_enable_pin(run_enable_pin),
    .thermal_prewarn_in(thermal_prewarn_in), .overtemp_in(overtemp_in),
    .load_supply_bad(load_supply_bad), .short_in(short_in), .open_load_in(open_load_in),
    .switch_on(switch_on), .open_load_src_en(open_load_src_en));

  slsc_ctrl_model ctrl_u (.sclk(sclk), .cs_n(cs_n), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .serial_data_out_oe_n(serial_data_out_oe_n));

  // Compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    // Seen is copied at the call; the wait for the falling edge does not resample it
    @(negedge core_clk);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One frame, then let the applied word reach the switches
  task automatic frame(input logic [15:0] w, input int n);
    ctrl_u.xfer(w, n, st);
    repeat (8) @(posedge core_clk);
  endtask

  task automatic wait_c(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic t_basic();
    chk("switch_on", {10'h000, switch_on}, 16'h0000);
    chk("oe_n", {15'h0000, serial_data_out_oe_n}, 16'h0001);
    @(posedge core_clk) thermal_prewarn_in <= 1'b1;
    wait_c(4);
    frame(16'he054, 16);
    chk("status", st, 16'h0001);
    chk("switch_on", {10'h000, switch_on}, 16'h002a);
    chk("ol_src", {10'h000, open_load_src_en}, 16'h0000);
    @(posedge core_clk) thermal_prewarn_in <= 1'b0;
    frame(16'he054, 16);
    chk("status", st, 16'h0054);
    frame(16'h0000, 7);
    chk("switch_on", {10'h000, switch_on}, 16'h002a);
    $display("basic done");
  endtask

  task automatic t_standby();
    frame(16'h6054, 16);
    chk("switch_on", {10'h000, switch_on}, 16'h0000);
    frame(16'he054, 16);
    chk("status", st, 16'h4000);
    @(posedge core_clk) run_enable_pin <= 1'b0;
    wait_c(8);
    chk("switch_on", {10'h000, switch_on}, 16'h0000);
    frame(16'he054, 16);
    chk("status", st & 16'hc001, 16'h4000);
    @(posedge core_clk) run_enable_pin <= 1'b1;
    wait_c(8);
    chk("switch_on", {10'h000, switch_on}, 16'h002a);
    $display("standby done");
  endtask

  task automatic t_openload();
    frame(16'hc002, 16);
    chk("ol_src", {10'h000, open_load_src_en}, 16'h003e);
    @(posedge core_clk) open_load_in <= 6'h04;
    frame(16'hc002, 16);
    chk("status", st, 16'h000a);
    frame(16'h4002, 16);
    chk("ol_src", {10'h000, open_load_src_en}, 16'h0000);
    @(posedge core_clk) open_load_in <= 6'h00;
    frame(16'he054, 16);
    $display("openload done");
  endtask

  task automatic t_supply();
    @(posedge core_clk) load_supply_bad <= 1'b1;
    wait_c(20);
    chk("switch_on", {10'h000, switch_on}, 16'h002a);
    wait_c(20);
    chk("switch_on", {10'h000, switch_on}, 16'h0000);
    @(posedge core_clk) load_supply_bad <= 1'b0;
    wait_c(6);
    chk("switch_on", {10'h000, switch_on}, 16'h002a);
    frame(16'ha054, 16);
    chk("status", st, 16'h8054);
    @(posedge core_clk) load_supply_bad <= 1'b1;
    wait_c(6);
    chk("switch_on", {10'h000, switch_on}, 16'h002a);
    wait_c(14);
    chk("switch_on", {10'h000, switch_on}, 16'h0000);
    @(posedge core_clk) load_supply_bad <= 1'b0;
    // Let the outputs come back before the status is captured
    wait_c(6);
    frame(16'ha055, 16);
    chk("status", st, 16'h8054);
    frame(16'ha054, 16);
    chk("status", st, 16'h0054);
    $display("supply done");
  endtask

  task automatic t_fault();
    @(posedge core_clk) short_in <= 6'h02;
    wait_c(12);
    chk("switch_on", {10'h000, switch_on}, 16'h002a);
    wait_c(20);
    chk("switch_on", {10'h000, switch_on}, 16'h0028);
    @(posedge core_clk) short_in <= 6'h00;
    frame(16'ha055, 16);
    chk("status", st & 16'h2000, 16'h2000);
    chk("switch_on", {10'h000, switch_on}, 16'h002a);
    @(posedge core_clk) overtemp_in <= 1'b1;
    wait_c(8);
    chk("switch_on", {10'h000, switch_on}, 16'h0000);
    frame(16'ha054, 16);
    chk("status", st, 16'hffff);
    @(posedge core_clk) overtemp_in <= 1'b0;
    wait_c(4);
    frame(16'ha055, 16);
    frame(16'ha054, 16);
    chk("status", st, 16'h0054);
    $display("fault done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    wait_c(10);
    rst <= 1'b0;
    wait_c(6);
    t_basic();
    t_standby();
    t_openload();
    t_supply();
    t_fault();
    stop_test();
  end

  // Watchdog well past the expected run of about 25 us
  initial begin
    #300000;
    err_total++;
    stop_test();
  end
endmodule

bind slsc_top slsc_checker #(.SC_LONG_CYC(SC_LONG_CYC), .SV_LONG_CYC(SV_LONG_CYC)) chk_u (
  .core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
  .serial_data_out(serial_data_out), .serial_data_out_oe_n(serial_data_out_oe_n),
  .run_enable_pin(run_enable_pin), .overtemp_in(overtemp_in),
  .load_supply_bad(load_supply_bad), .short_in(short_in), .switch_on(switch_on),
  .open_load_src_en(open_load_src_en));
